// file: rtl/core_exec_pkg.sv
package core_exec_pkg;
   // Register offsets on the bus (byte addresses, one word each)
   localparam logic [9:0] ADR_CTRL  = 10'h000;
   localparam logic [9:0] ADR_LATCH = 10'h004;
   localparam logic [9:0] ADR_WREG  = 10'h008;
   localparam logic [9:0] ADR_STAT  = 10'h00c;
   localparam logic [9:0] ADR_PCNT  = 10'h010;
   localparam logic [9:0] ADR_WDOG  = 10'h014;
   localparam logic [9:0] ADR_STACK = 10'h018;
   localparam int         ADR_FILE_BIT = 9;   // Set: file register window
   // Field positions
   localparam int CTRL_RUN     = 0;
   localparam int STAT_ZERO    = 0;
   localparam int STAT_SLEEP_N = 1;
   localparam int STAT_EXPIRY_N = 2;
   localparam int STAT_IDLE    = 3;
   localparam int LATCH_HI     = 4;
   localparam int LATCH_LO     = 3;
   // Values after reset
   localparam logic [12:0] PC_RST    = 13'h0000;
   localparam logic [7:0]  BYTE_RST  = 8'h00;
   localparam logic        ZERO_RST  = 1'b0;
   localparam logic        FLAG_N_RST = 1'b1;
   localparam logic        RUN_RST   = 1'b0;
   // Sizes
   localparam int FILE_DEPTH  = 128;
   localparam int STACK_DEPTH = 8;
   // Operation classes of the supported subset
   typedef enum logic [3:0] {
      none_op, bit_clear_op, bit_set_op, test_skip_if_zero_op, test_skip_if_one_op,
      and_immediate_op, clear_file_op, clear_working_op, call_op, watchdog_clear_op
   } op_t;
   typedef enum logic {st_exec, st_idle} state_t;

   // Map a 14-bit instruction word to its operation class
   function automatic op_t decode(input logic [13:0] iw);
      if (iw[13:12] == 2'h1) begin
         unique case (iw[11:10])
            2'h0: return bit_clear_op;
            2'h1: return bit_set_op;
            2'h2: return test_skip_if_zero_op;
            2'h3: return test_skip_if_one_op;
         endcase
      end
      if (iw[13:8] == 6'h39) return and_immediate_op;
      if (iw[13:11] == 3'h4) return call_op;
      if (iw[13:7] == 7'h03) return clear_file_op;
      if (iw[13:7] == 7'h02) return clear_working_op;
      if (iw == 14'h0064) return watchdog_clear_op;
      return none_op;
   endfunction : decode
endpackage : core_exec_pkg

// file: rtl/core_instruction_subset_exec.sv
// Function
// - Bit clear forces bit b of file register f to zero and leaves the flags alone.
// - AND immediate ANDs the working register with an 8-bit literal, stores it, sets zero only on a zero result.
// - Bit set forces bit b of file register f to one and leaves the flags alone.
// - Skip-if-zero runs the next word on a one, else discards it with an idle cycle.
// - Skip-if-one runs the next word on a zero, else discards it with an idle cycle.
// - Clear file writes zero to file register f and sets the zero flag.
// - Clear working writes zero to the working register and sets the zero flag.
// - A call first pushes the counter plus one onto the return stack.
// - A call loads its 11-bit target into counter bits 10 to 0.
// - A call fills counter bits 12 and 11 from latch bits 4 and 3.
// - A call always takes two instruction cycles.
// - Watchdog clear zeroes the watchdog counter and its prescaler.
// - Watchdog clear sets the expiry and sleep flags (both active low) to one.
`timescale 1ns/1ps
module core_instruction_subset_exec
   import core_exec_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   // Fetch path
   input  wire logic        instr_valid,
   input  wire logic [13:0] instr_word,
   output logic [12:0]      program_counter_q,
   output logic             idle_cycle_q,
   // Core state
   output logic [7:0]       working_q,
   output logic             zero_q,
   output logic             expiry_flag_n_q,
   output logic             sleep_flag_n_q,
   output logic [12:0]      stack_top_q,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);

   // Next sequential address; used by the counter and the stack
   function automatic logic [12:0] inc_pc(input logic [12:0] pc);
      return 13'(pc + 13'h0001);
   endfunction : inc_pc

   // -----------------------------------------------------------
   // Storage and decode
   // -----------------------------------------------------------
   // Memories: 128 file bytes and an eight-word return stack
   logic [7:0]  file_q [FILE_DEPTH];
   logic [12:0] stack_q [STACK_DEPTH];
   logic [2:0]  sp_q;
   logic [7:0]  latch_q;
   logic        run_q;
   logic [7:0]  wdog_q;
   logic [7:0]  presc_q;
   state_t      state_q;
   // Decode of the word on the fetch port
   op_t         op;
   logic [6:0]  fa;
   logic [2:0]  bi;
   logic        go;
   logic        tbit;
   logic        skip;
   logic        fwr;
   logic [7:0]  fdat;
   logic [7:0]  and_res;
   logic        idle_call_q;

   // Only an executing slot takes a word; the idle slot drops it
   assign go      = run_q && instr_valid && (state_q == st_exec);
   assign op      = decode(instr_word);
   assign fa      = instr_word[6:0];
   assign bi      = instr_word[9:7];
   assign tbit    = file_q[fa][bi];
   assign and_res = working_q & instr_word[7:0];
   assign skip    = go && ((op == test_skip_if_zero_op && !tbit)
                        || (op == test_skip_if_one_op && tbit));

   // File write from the core: read-modify-write of one bit, or clear
   always_comb begin
      fdat = file_q[fa];
      fwr  = go && (op == bit_clear_op || op == bit_set_op || op == clear_file_op);
      if (op == bit_clear_op) fdat[bi] = 1'b0;
      if (op == bit_set_op) fdat[bi] = 1'b1;
      if (op == clear_file_op) fdat = BYTE_RST;
   end

   // -----------------------------------------------------------
   // Bus slave
   // -----------------------------------------------------------
   // Request decode
   logic hit;
   logic ack_d;
   logic bwr;
   logic [31:0] rd_d;

   // A file access waits for as long as the core writes the file
   assign hit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign ack_d = hit && !(wb_adr_i[ADR_FILE_BIT] && fwr);
   assign bwr   = ack_d && wb_we_i && wb_sel_i[0];

   // Read multiplexer; every register sits in the low bits of its word
   always_comb begin
      rd_d = '0;
      if (wb_adr_i[ADR_FILE_BIT]) rd_d[7:0] = file_q[wb_adr_i[8:2]];
      else begin
         unique case (wb_adr_i)
            ADR_CTRL:  rd_d[CTRL_RUN] = run_q;
            ADR_LATCH: rd_d[7:0] = latch_q;
            ADR_WREG:  rd_d[7:0] = working_q;
            ADR_STAT:  rd_d[3:0] = {idle_cycle_q, expiry_flag_n_q, sleep_flag_n_q, zero_q};
            ADR_PCNT:  rd_d[12:0] = program_counter_q;
            ADR_WDOG:  rd_d[15:0] = {presc_q, wdog_q};
            ADR_STACK: rd_d[15:0] = {sp_q, stack_top_q};
            default:   rd_d = '0; // Unmapped reads as zero
         endcase
      end
   end

   // Ack is a single-cycle pulse; read data is latched with it
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= ack_d;
         if (ack_d) wb_dat_o <= rd_d;
      end
   end

   // Software control and latch registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q   <= RUN_RST;
         latch_q <= BYTE_RST;
      end else if (bwr && !wb_adr_i[ADR_FILE_BIT]) begin
         if (wb_adr_i == ADR_CTRL) run_q <= wb_dat_i[CTRL_RUN];
         if (wb_adr_i == ADR_LATCH) latch_q <= wb_dat_i[7:0];
      end
   end

   // File array; no reset, so software loads it before use
   always_ff @(posedge sys_clk) begin
      if (bwr && wb_adr_i[ADR_FILE_BIT]) file_q[wb_adr_i[8:2]] <= wb_dat_i[7:0];
      if (fwr) file_q[fa] <= fdat;
   end

   // -----------------------------------------------------------
   // Sequencing and program counter
   // -----------------------------------------------------------
   // Skip and call both insert exactly one idle slot
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q      <= st_exec;
         idle_cycle_q <= 1'b0;
      end else begin
         unique case (state_q)
            st_exec: begin
               if (skip || (go && op == call_op)) begin
                  state_q      <= st_idle;
                  idle_cycle_q <= 1'b1;
               end
            end
            st_idle: begin // never entered on a failed test
               state_q      <= st_exec;
               idle_cycle_q <= 1'b0;
            end
         endcase
      end
   end

   // Idle after a skip steps over the dropped word; idle after a call holds
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) program_counter_q <= PC_RST;
      else if (go && op == call_op)
         program_counter_q <= {latch_q[LATCH_HI:LATCH_LO], instr_word[10:0]};
      else if (go) program_counter_q <= inc_pc(program_counter_q);
      else if (state_q == st_idle && !idle_call_q) program_counter_q <= inc_pc(program_counter_q);
   end

   // Marks the idle slot that follows a call, where the counter holds
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) idle_call_q <= 1'b0;
      else idle_call_q <= go && op == call_op;
   end

   // Return stack: wraps silently after eight pushes, as the core has no overflow trap
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sp_q        <= 3'h0;
         stack_top_q <= PC_RST;
      end else if (go && op == call_op) begin
         stack_top_q   <= inc_pc(program_counter_q);
         sp_q          <= 3'(sp_q + 3'h1);
      end
   end

   // Stack array has no reset, so it stays out of the reset process
   always_ff @(posedge sys_clk) begin
      if (go && op == call_op) stack_q[sp_q] <= inc_pc(program_counter_q);
   end

   // -----------------------------------------------------------
   // Working register and flags
   // -----------------------------------------------------------
   // Core updates come after bus writes so an instruction wins a tie
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         working_q <= BYTE_RST;
         zero_q    <= ZERO_RST;
      end else begin
         if (bwr && wb_adr_i == ADR_WREG) working_q <= wb_dat_i[7:0];
         if (bwr && wb_adr_i == ADR_STAT) zero_q <= wb_dat_i[STAT_ZERO];
         if (go && op == and_immediate_op) begin
            working_q <= and_res;
            zero_q    <= (and_res == 8'h00);
         end
         if (go && op == clear_file_op) zero_q <= 1'b1;
         if (go && op == clear_working_op) begin
            working_q <= BYTE_RST;
            zero_q    <= 1'b1;
         end
      end
   end

   // Status flags: software may clear them, the clear instruction wins
   // Software writes let a test lower the flags before a clear
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         expiry_flag_n_q <= FLAG_N_RST;
         sleep_flag_n_q  <= FLAG_N_RST;
      end else if (go && op == watchdog_clear_op) begin
         expiry_flag_n_q <= 1'b1;
         sleep_flag_n_q  <= 1'b1;
      end else if (bwr && wb_adr_i == ADR_STAT) begin
         expiry_flag_n_q <= wb_dat_i[STAT_EXPIRY_N];
         sleep_flag_n_q  <= wb_dat_i[STAT_SLEEP_N];
      end
   end

   // Watchdog: prescaler divides the clock, counter steps on its wrap
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         presc_q <= BYTE_RST;
         wdog_q  <= BYTE_RST;
      end else if (go && op == watchdog_clear_op) begin
         presc_q <= BYTE_RST;
         wdog_q  <= BYTE_RST;
      end else if (run_q) begin
         presc_q <= 8'(presc_q + 8'h01);
         if (presc_q == 8'hff) wdog_q <= 8'(wdog_q + 8'h01);
      end
   end

   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // Bit operations on the file: the target bit moves, the flags stay
   a_bit_clear_one: assert property (go && op == bit_clear_op |=>
      file_q[$past(fa)][$past(bi)] == 1'b0 && $stable(zero_q))
      else $error("bit clear failed");

   // AND immediate result and its zero flag
   a_and_imm_res: assert property (go && op == and_immediate_op |=>
      working_q == $past(and_res) && zero_q == ($past(and_res) == 8'h00))
      else $error("and immediate wrong");

   // Bit set, then the two skipping tests
   a_bit_set_one: assert property (go && op == bit_set_op |=>
      file_q[$past(fa)][$past(bi)] == 1'b1 && $stable(zero_q))
      else $error("bit set failed");
   a_skip_zero_idle: assert property (go && op == test_skip_if_zero_op && !tbit |=>
      idle_cycle_q ##1 !idle_cycle_q)
      else $error("skip on zero missing");
   a_skip_one_idle: assert property (go && op == test_skip_if_one_op && tbit |=>
      idle_cycle_q && program_counter_q == inc_pc($past(program_counter_q)))
      else $error("skip on one missing");

   // Clears always leave the zero flag set
   a_clear_file_z: assert property (go && op == clear_file_op |=>
      file_q[$past(fa)] == 8'h00 && zero_q)
      else $error("clear file wrong");
   a_clear_w_z: assert property (go && op == clear_working_op |=>
      working_q == 8'h00 && zero_q)
      else $error("clear working wrong");

   // Subroutine call: push, load and the idle slot
   a_call_push_ret: assert property (go && op == call_op |=>
      stack_top_q == inc_pc($past(program_counter_q)) && sp_q == 3'($past(sp_q) + 3'h1))
      else $error("call push wrong");
   a_call_pc_load: assert property (go && op == call_op |=>
      program_counter_q == {$past(latch_q[4:3]), $past(instr_word[10:0])})
      else $error("call target wrong");
   a_call_two_cyc: assert property (go && op == call_op |=>
      idle_cycle_q && !go ##1 !idle_cycle_q && $stable(program_counter_q))
      else $error("call not two cycles");

   // Watchdog clear and the single-cycle test
   a_wdog_clear_all: assert property (go && op == watchdog_clear_op |=>
      wdog_q == 8'h00 && presc_q == 8'h00 && expiry_flag_n_q && sleep_flag_n_q)
      else $error("watchdog clear wrong");
   a_noskip_single: assert property (go && !skip && op != call_op |=>
      !idle_cycle_q)
      else $error("failed test idled");

   // Only the addressed bit of the file register may change
   a_bit_keep_rest: assert property (
      go && (op == bit_clear_op || op == bit_set_op) |=>
      ((file_q[$past(fa)] ^ $past(file_q[fa])) & ~(8'h01 << $past(bi))) == 8'h00)
      else $error("bit op touched other bits");
   // A taken skip on zero lands two words on, after one idle slot
   a_skip_zero_pc: assert property (go && op == test_skip_if_zero_op && !tbit |=>
      ##1 !idle_cycle_q && program_counter_q == inc_pc(inc_pc($past(program_counter_q, 2))))
      else $error("skip on zero counter wrong");
   // A failed test advances one word and inserts nothing
   a_test_one_step: assert property (
      go && !skip && (op == test_skip_if_zero_op || op == test_skip_if_one_op) |=>
      !idle_cycle_q && program_counter_q == inc_pc($past(program_counter_q)))
      else $error("failed test not one step");
   // The pushed return address sits in the slot that was free
   a_stack_entry: assert property (go && op == call_op |=>
      stack_q[$past(sp_q)] == inc_pc($past(program_counter_q)))
      else $error("stack entry wrong");
   // With run off nothing is taken, so the counter holds
   a_run_off_hold: assert property (!run_q && state_q == st_exec |=>
      $stable(program_counter_q))
      else $error("counter moved while stopped");
   // Ack stands one cycle, so a held request is answered every other cycle
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   // Main scenarios worth seeing in a run
   c_call_taken: cover property (go && op == call_op ##2 go);
   c_skip_taken: cover property (skip ##1 idle_cycle_q);
   c_test_pass: cover property (go && op == test_skip_if_one_op && !tbit);
   c_file_stall: cover property (hit && wb_adr_i[ADR_FILE_BIT] && fwr);
   c_wdog_clear: cover property (go && op == watchdog_clear_op);

endmodule : core_instruction_subset_exec

// file: test/test_core_instruction_subset_exec.sv
`timescale 1ns/1ps
module test_core_instruction_subset_exec
   import core_exec_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        sys_clk;
   logic        rst_b;
   logic        instr_valid;
   logic [13:0] instr_word;
   logic [12:0] program_counter_q;
   logic        idle_cycle_q;
   logic [7:0]  working_q;
   logic        zero_q;
   logic        expiry_flag_n_q;
   logic        sleep_flag_n_q;
   logic [12:0] stack_top_q;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [9:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [31:0] rdat;
   int          error_cnt;
   int          n_tests;
   localparam logic [13:0] clr_w_word = 14'h0100;

   core_instruction_subset_exec core_instruction_subset_exec_i (
      .sys_clk, .rst_b, .instr_valid, .instr_word, .program_counter_q, .idle_cycle_q,
      .working_q, .zero_q, .expiry_flag_n_q, .sleep_flag_n_q, .stack_top_q,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Clock: 25 MHz
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [13:0] bop(input logic [1:0] o, input int b, input int f);
      return {2'h1, o, 3'(b), 7'(f)};
   endfunction : bop

   // Classic single cycle; the request stays up until ack is sampled high
   task automatic wb_xfer(input logic we, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      rdat = wb_dat_o;
      if (n >= 40) error_cnt++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb_xfer

   // One word, effects looked at just after the taking edge
   task automatic exec(input logic [13:0] w);
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word  <= w;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      #1;
   endtask : exec

   // Two back-to-back words; idle flag and counter seen between them
   task automatic pair(input logic [13:0] w1, w2, output logic i1, output logic [12:0] p1);
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word  <= w1;
      @(posedge sys_clk);
      instr_word  <= w2;
      #1;
      i1 = idle_cycle_q;
      p1 = program_counter_q;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      #1;
   endtask : pair

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_bits;
      wb_xfer(1'b1, {1'b1, 7'd5, 2'h0}, 32'h0f);
      wb_xfer(1'b1, {1'b1, 7'd127, 2'h0}, 32'h00);
      wb_xfer(1'b1, ADR_STAT, 32'h7);
      exec(bop(2'h1, 7, 5));
      exec(bop(2'h0, 0, 5));
      exec(bop(2'h1, 7, 127));
      check(zero_q, 1'b1);
      wb_xfer(1'b0, {1'b1, 7'd5, 2'h0}, 32'h0);
      check(rdat, 32'h8e);
      wb_xfer(1'b0, {1'b1, 7'd127, 2'h0}, 32'h0);
      check(rdat, 32'h80);
   endtask : t_bits

   task automatic t_and_clear;
      wb_xfer(1'b1, ADR_WREG, 32'h3c);
      exec({6'h39, 8'hf5});
      check(working_q, 8'h34);
      check(zero_q, 1'b0);
      exec({6'h39, 8'h03});
      check(working_q, 8'h00);
      check(zero_q, 1'b1);
      wb_xfer(1'b1, ADR_STAT, 32'h0);
      exec(14'h0185);
      check(zero_q, 1'b1);
      wb_xfer(1'b0, {1'b1, 7'd5, 2'h0}, 32'h0);
      check(rdat, 32'h0);
      wb_xfer(1'b1, ADR_WREG, 32'h55);
      wb_xfer(1'b1, ADR_STAT, 32'h0);
      exec(clr_w_word);
      check(working_q, 8'h00);
      check(zero_q, 1'b1);
   endtask : t_and_clear

   // A discarded clear-working word shows whether the skip really happened
   task automatic skip_case(input logic [13:0] w, input logic taken);
      logic [12:0] p;
      logic [12:0] p1;
      logic        i1;
      wb_xfer(1'b1, ADR_WREG, 32'h77);
      p = program_counter_q;
      pair(w, clr_w_word, i1, p1);
      check(i1, taken);
      check(p1, 13'(p + 13'h1));
      check(program_counter_q, 13'(p + 13'h2));
      check(working_q, taken ? 8'h77 : 8'h00);
   endtask : skip_case

   // Latch bits around 4:3 are set where they must not leak
   task automatic t_call;
      logic [7:0]  lat [3] = '{8'h18, 8'h08, 8'he7};
      logic [10:0] k   [3] = '{11'h5a5, 11'h7ff, 11'h001};
      logic [12:0] p;
      logic [12:0] p1;
      logic        i1;
      wb_xfer(1'b1, ADR_WREG, 32'h77);
      for (int j = 0; j < 3; j++) begin
         wb_xfer(1'b1, ADR_LATCH, {24'h0, lat[j]});
         p = program_counter_q;
         pair({3'h4, k[j]}, clr_w_word, i1, p1);
         check(stack_top_q, 13'(p + 13'h1));
         check(p1, {lat[j][4:3], k[j]});
         check(i1, 1'b1);
         check(program_counter_q, p1);
         check(idle_cycle_q, 1'b0);
         check(working_q, 8'h77);
      end
   endtask : t_call

   task automatic t_wdog;
      repeat (600) @(posedge sys_clk);
      wb_xfer(1'b0, ADR_WDOG, 32'h0);
      check(rdat[7:0] != 8'h00, 1'b1);
      wb_xfer(1'b1, ADR_STAT, 32'h0);
      exec(14'h0064);
      check(expiry_flag_n_q, 1'b1);
      check(sleep_flag_n_q, 1'b1);
      check(zero_q, 1'b0);
      wb_xfer(1'b0, ADR_WDOG, 32'h0);
      check(rdat[7:0], 8'h00);
      check(rdat[15:8] < 8'h03, 1'b1);
   endtask : t_wdog

   // ------------------------------------------------------------
   // Sequence and verdict
   // ------------------------------------------------------------
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   // Main sequence; flags are read back after reset, unmapped space reads zero
   initial begin
      error_cnt = 0;
      n_tests = 0;
      rst_b = 1'b0;
      instr_valid = 1'b0;
      instr_word = 14'h0;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_adr_i = 10'h0;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      wb_xfer(1'b0, ADR_STAT, 32'h0);
      check(rdat, 32'h6);
      wb_xfer(1'b1, 10'h100, 32'hff);
      wb_xfer(1'b0, 10'h100, 32'h0);
      check(rdat, 32'h0);
      wb_xfer(1'b1, ADR_CTRL, 32'h1);
      t_bits();
      t_and_clear();
      skip_case(bop(2'h2, 3, 5), 1'b1);
      skip_case(bop(2'h3, 3, 5), 1'b0);
      wb_xfer(1'b1, {1'b1, 7'd5, 2'h0}, 32'h08);
      skip_case(bop(2'h3, 3, 5), 1'b1);
      skip_case(bop(2'h2, 3, 5), 1'b0);
      t_call();
      t_wdog();
      report_and_stop();
   end

   // Hang guard, well beyond the roughly 750 cycles the sequence needs
   initial begin
      repeat (5000) @(posedge sys_clk);
      error_cnt++;
      report_and_stop();
   end
endmodule : test_core_instruction_subset_exec
